// >>> design/fodl_pkg.sv
// constants for the fault output dependency logic
package fodl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_SEC_MASK = 8'h1E;
   localparam logic [7:0] ADDR_OT_MASK = 8'h1F;
   localparam logic [7:0] ADDR_RST_CFG = 8'h20;
   localparam logic [7:0] ADDR_LATCH_CLR = 8'h50;
   localparam logic [7:0] ADDR_STATUS = 8'h51;
   localparam logic [7:0] SEC_MASK_RST = 8'h00;
   localparam logic [7:0] OT_MASK_RST = 8'h00;
   localparam logic [7:0] RST_CFG_RST = 8'h00;
   localparam logic [7:0] MASK_USED = 8'h7F;
   localparam int SEC_UV2 = 0;
   localparam int SEC_OV1 = 1;
   localparam int SEC_OV2 = 2;
   localparam int SEC_OT2 = 3;
   localparam int SEC_OC2 = 6;
   localparam int OT_OT1 = 0;
   localparam int OT_DIODE = 3;
   localparam int TMO_LSB = 3;
   localparam int TMO_MSB = 5;
   localparam int CLK_MHZ = 50;
   localparam int unsigned HOLD_US_0 = 25;
   localparam int unsigned HOLD_US_1 = 2500;
   localparam int unsigned HOLD_US_2 = 10000;
   localparam int unsigned HOLD_US_3 = 40000;
   localparam int unsigned HOLD_US_4 = 160000;
   localparam int unsigned HOLD_US_5 = 640000;
   localparam int unsigned HOLD_US_6 = 1280000;
   localparam int unsigned HOLD_US_7 = 2560000;
   typedef enum logic [1:0] {RST_IDLE, RST_ACTIVE, RST_HOLD} fodl_rst_state_t;
endpackage

// >>> design/fodl_top.sv
// fault output dependency logic: mask registers, diode latch, reset hold timer
`timescale 1ns/10ps
module fodl_top
   import fodl_pkg::*;
#(
   parameter int NUM_IN = 8,
   parameter int unsigned HOLD_US [8] = '{HOLD_US_0, HOLD_US_1, HOLD_US_2, HOLD_US_3,
                                          HOLD_US_4, HOLD_US_5, HOLD_US_6, HOLD_US_7}
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   input wire logic [NUM_IN-1:0] vin_enable_i,
   input wire logic [NUM_IN-1:0] vin_uv2_i,
   input wire logic [NUM_IN-1:0] vin_ov1_i,
   input wire logic [NUM_IN-1:0] vin_ov2_i,
   input wire logic [2:0] temp_ot1_i,
   input wire logic [2:0] temp_ot2_i,
   input wire logic curr_oc2_i,
   input wire logic [1:0] diode_short_i,
   input wire logic [1:0] diode_open_i,
   input wire logic reset_cond_i,
   input wire logic alert_enable_i,
   output logic secondary_fault_out_n_o,
   output logic secondary_fault_out_oe_o,
   output logic overtemp_out_n_o,
   output logic overtemp_out_oe_o,
   output logic reset_out_n_o,
   output logic reset_out_oe_o,
   output logic smb_alert_n_o,
   output logic smb_alert_oe_o
);
   logic [7:0] sec_mask_q;
   logic [7:0] ot_mask_q;
   logic [7:0] rst_cfg_q;
   logic [3:0] diode_latch_q;
   logic [3:0] diode_latch_d;
   logic [31:0] hold_cnt_q;
   logic [31:0] hold_cnt_d;
   fodl_rst_state_t rst_state_q;
   fodl_rst_state_t rst_state_d;
   logic sec_fault_q;
   logic ot_fault_q;
   logic rst_act_q;

   function automatic logic [31:0] hold_cycles(input logic [2:0] sel);
      hold_cycles = 32'(HOLD_US[sel] * CLK_MHZ);
   endfunction

   wire we_sec = reg_we_i && (reg_addr_i == ADDR_SEC_MASK);
   wire we_ot = reg_we_i && (reg_addr_i == ADDR_OT_MASK);
   wire we_cfg = reg_we_i && (reg_addr_i == ADDR_RST_CFG);
   wire we_clr = reg_we_i && (reg_addr_i == ADDR_LATCH_CLR);

   // voltage conditions over enabled inputs only
   wire any_uv2 = |(vin_uv2_i & vin_enable_i);
   wire any_ov1 = |(vin_ov1_i & vin_enable_i);
   wire any_ov2 = |(vin_ov2_i & vin_enable_i);
   wire [6:0] sec_src = {curr_oc2_i, temp_ot2_i, any_ov2, any_ov1, any_uv2};
   wire sec_fault_d = |(sec_src & sec_mask_q[6:0]);

   // diode flags in mask bit order 3..6
   wire [3:0] diode_src = {diode_open_i[1], diode_short_i[1], diode_open_i[0], diode_short_i[0]};
   wire [3:0] diode_set = diode_src & ot_mask_q[OT_DIODE+3:OT_DIODE];
   // sticky latch; a new set wins over the clear
   assign diode_latch_d = (we_clr ? 4'h0 : diode_latch_q) | diode_set;
   // primary overtemperature masked OR plus latch
   wire ot_fault_d = |(temp_ot1_i & ot_mask_q[OT_OT1+2:OT_OT1]) | (|diode_latch_d);

   wire [2:0] tmo_sel = rst_cfg_q[TMO_MSB:TMO_LSB];

   always_comb begin
      rst_state_d = rst_state_q;
      hold_cnt_d = hold_cnt_q;
      case (rst_state_q)
         RST_IDLE: begin
            if (reset_cond_i) rst_state_d = RST_ACTIVE;
         end
         RST_ACTIVE: begin
            if (!reset_cond_i) begin
               rst_state_d = RST_HOLD;
               hold_cnt_d = hold_cycles(tmo_sel) - 32'h1;
            end
         end
         RST_HOLD: begin
            if (reset_cond_i) rst_state_d = RST_ACTIVE;
            else if (hold_cnt_q == 32'h0) rst_state_d = RST_IDLE;
            else hold_cnt_d = hold_cnt_q - 32'h1;
         end
         default: rst_state_d = RST_IDLE;
      endcase
   end
   wire rst_act_d = (rst_state_d != RST_IDLE);
   // alert follows fault outputs when enabled
   wire alert_d = alert_enable_i && (sec_fault_d || ot_fault_d || rst_act_d);

   wire [7:0] status_val = {5'h00, rst_act_q, ot_fault_q, sec_fault_q};
   wire [7:0] rdata_d = (reg_addr_i == ADDR_SEC_MASK) ? sec_mask_q :
                        (reg_addr_i == ADDR_OT_MASK) ? ot_mask_q :
                        (reg_addr_i == ADDR_RST_CFG) ? rst_cfg_q :
                        (reg_addr_i == ADDR_STATUS) ? {diode_latch_q, status_val[3:0]} :
                        8'h00;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sec_mask_q <= SEC_MASK_RST;
         ot_mask_q <= OT_MASK_RST;
         rst_cfg_q <= RST_CFG_RST;
         diode_latch_q <= 4'h0;
         rst_state_q <= RST_IDLE;
         hold_cnt_q <= 32'h0;
         sec_fault_q <= 1'b0;
         ot_fault_q <= 1'b0;
         rst_act_q <= 1'b0;
         smb_alert_oe_o <= 1'b0;
         reg_rdata_o <= 8'h00;
      end else begin
         if (we_sec) sec_mask_q <= reg_wdata_i & MASK_USED;
         if (we_ot) ot_mask_q <= reg_wdata_i & MASK_USED;
         if (we_cfg) rst_cfg_q <= reg_wdata_i;
         diode_latch_q <= diode_latch_d;
         rst_state_q <= rst_state_d;
         hold_cnt_q <= hold_cnt_d;
         sec_fault_q <= sec_fault_d;
         ot_fault_q <= ot_fault_d;
         rst_act_q <= rst_act_d;
         smb_alert_oe_o <= alert_d;
         reg_rdata_o <= rdata_d;
      end
   end

   // open-drain pins: drive low while asserted
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         secondary_fault_out_n_o <= 1'b1;
         secondary_fault_out_oe_o <= 1'b0;
         overtemp_out_n_o <= 1'b1;
         overtemp_out_oe_o <= 1'b0;
         reset_out_n_o <= 1'b1;
         reset_out_oe_o <= 1'b0;
         smb_alert_n_o <= 1'b1;
      end else begin
         secondary_fault_out_n_o <= !sec_fault_d;
         secondary_fault_out_oe_o <= sec_fault_d;
         overtemp_out_n_o <= !ot_fault_d;
         overtemp_out_oe_o <= ot_fault_d;
         reset_out_n_o <= !rst_act_d;
         reset_out_oe_o <= rst_act_d;
         smb_alert_n_o <= !alert_d;
      end
   end

   // masked-off sources never reach the pin
   a_sec_masked_off: assert property (@(posedge clk_i) disable iff (srst_i)
      (sec_mask_q[6:0] == 7'h00) |=> secondary_fault_out_n_o)
      else $error("secondary fault asserted with empty mask");
   a_uv2_drives_sec: assert property (@(posedge clk_i) disable iff (srst_i)
      (sec_mask_q[SEC_UV2] && any_uv2) |=> !secondary_fault_out_n_o)
      else $error("undervoltage did not assert secondary fault");
   a_ov1_drives_sec: assert property (@(posedge clk_i) disable iff (srst_i)
      (sec_mask_q[SEC_OV1] && any_ov1) |=> secondary_fault_out_oe_o)
      else $error("overvoltage one did not drive secondary fault");
   a_ov2_drives_sec: assert property (@(posedge clk_i) disable iff (srst_i)
      (sec_mask_q[SEC_OV2] && any_ov2) |=> !secondary_fault_out_n_o)
      else $error("overvoltage two did not assert secondary fault");
   a_oc2_drives_sec: assert property (@(posedge clk_i) disable iff (srst_i)
      (sec_mask_q[SEC_OC2] && curr_oc2_i) |=> !secondary_fault_out_n_o)
      else $error("overcurrent did not assert secondary fault");
   a_ot2_drives_sec: assert property (@(posedge clk_i) disable iff (srst_i)
      (|(sec_mask_q[SEC_OT2+2:SEC_OT2] & temp_ot2_i)) |=> !secondary_fault_out_n_o)
      else $error("secondary overtemperature missed");
   a_ot1_drives_ot: assert property (@(posedge clk_i) disable iff (srst_i)
      (|(ot_mask_q[2:0] & temp_ot1_i)) |=> !overtemp_out_n_o)
      else $error("primary overtemperature missed");
   a_diode_latch_hold: assert property (@(posedge clk_i) disable iff (srst_i)
      ((|diode_set) ##1 (!we_clr && diode_set == 4'h0)[*3]) |=> !overtemp_out_n_o)
      else $error("diode latch released without clear");
   a_short1_sets: assert property (@(posedge clk_i) disable iff (srst_i)
      (ot_mask_q[OT_DIODE] && diode_short_i[0]) |=> diode_latch_q[0])
      else $error("remote one short not latched");
   a_open2_sets: assert property (@(posedge clk_i) disable iff (srst_i)
      (ot_mask_q[OT_DIODE+3] && diode_open_i[1]) |=> diode_latch_q[3])
      else $error("remote two open not latched");
   a_clear_releases: assert property (@(posedge clk_i) disable iff (srst_i)
      (we_clr && diode_set == 4'h0) |=> (diode_latch_q == 4'h0))
      else $error("clear write did not release latch");
   a_hold_load: assert property (@(posedge clk_i) disable iff (srst_i)
      (rst_state_q == RST_ACTIVE && !reset_cond_i)
      |=> (hold_cnt_q == hold_cycles($past(tmo_sel)) - 32'h1))
      else $error("hold count not loaded from timeout field");
   a_hold_keeps_rst: assert property (@(posedge clk_i) disable iff (srst_i)
      (rst_state_q == RST_HOLD && hold_cnt_q != 32'h0) |=> !reset_out_n_o)
      else $error("reset output released early");
   a_alert_follows: assert property (@(posedge clk_i) disable iff (srst_i)
      (alert_enable_i && (sec_fault_d || ot_fault_d)) |=> !smb_alert_n_o)
      else $error("alert not asserted with fault output");
   c_sec_fault: cover property (@(posedge clk_i) disable iff (srst_i)
      $fell(secondary_fault_out_n_o));
   c_diode_clear: cover property (@(posedge clk_i) disable iff (srst_i)
      (|diode_latch_q) ##1 we_clr ##1 overtemp_out_n_o);
   c_reset_hold: cover property (@(posedge clk_i) disable iff (srst_i)
      (rst_state_q == RST_HOLD) ##1 (rst_state_q == RST_IDLE));
   c_alert: cover property (@(posedge clk_i) disable iff (srst_i) $fell(smb_alert_n_o));
endmodule

// >>> testbench/fodl_pins.sv
// far-side model: open-drain fault lines seen through board pull-ups
`timescale 1ns/10ps
module fodl_pins (
   input wire logic [3:0] oe_i,
   input wire logic [3:0] drv_n_i,
   output logic [3:0] pin_o
);
   // line is pulled high unless its driver sinks it
   assign pin_o = ~(oe_i & ~drv_n_i);
endmodule

// >>> testbench/fodl_top_bench.sv
// self-checking bench for the fault output dependency logic
`timescale 1ns/10ps
module fodl_top_bench;
   import fodl_pkg::*;
   localparam int unsigned HU [8] = '{1, 2, 3, 4, 5, 6, 7, 8};
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] vin_en = 8'hFF;
   logic we = 1'b0;
   logic rc = 1'b0;
   logic ae = 1'b0;
   logic [13:0] cv = 14'h0000;
   logic [7:0] rd;
   logic [3:0] drv_n;
   logic [3:0] oe;
   logic [3:0] pin;
   int err_total = 0;
   int cmp_count = 0;
   int n;
   fodl_top #(.HOLD_US(HU)) uut (
      .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
      .reg_rdata_o(rd), .vin_enable_i(vin_en), .vin_uv2_i({7'h00, cv[0]}),
      .vin_ov1_i({7'h00, cv[1]}), .vin_ov2_i({7'h00, cv[2]}), .temp_ot1_i(cv[9:7]),
      .temp_ot2_i(cv[5:3]), .curr_oc2_i(cv[6]), .diode_short_i({cv[12], cv[10]}),
      .diode_open_i({cv[13], cv[11]}), .reset_cond_i(rc), .alert_enable_i(ae),
      .secondary_fault_out_n_o(drv_n[3]), .secondary_fault_out_oe_o(oe[3]),
      .overtemp_out_n_o(drv_n[2]), .overtemp_out_oe_o(oe[2]),
      .reset_out_n_o(drv_n[1]), .reset_out_oe_o(oe[1]),
      .smb_alert_n_o(drv_n[0]), .smb_alert_oe_o(oe[0])
   );
   fodl_pins far (.oe_i(oe), .drv_n_i(drv_n), .pin_o(pin));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      we = 1'b1;
      tick(1);
      we = 1'b0;
      tick(1);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      tick(2);
      cmp(rd, e);
   endtask
   // pins ordered {secondary, overtemp, reset, alert}
   task automatic pins(input logic [3:0] e);
      tick(2);
      cmp({4'h0, pin}, {4'h0, e});
      // drivers themselves: sink low, enable high while asserted
      cmp({oe, drv_n}, {~e, e});
   endtask
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      tick(3);
      srst_i = 1'b0;
      rd_chk(ADDR_SEC_MASK, SEC_MASK_RST);
      rd_chk(ADDR_OT_MASK, OT_MASK_RST);
      rd_chk(ADDR_RST_CFG, RST_CFG_RST);
      rd_chk(8'h33, 8'h00);
      rd_chk(ADDR_STATUS, 8'h00);
      wr(ADDR_SEC_MASK, 8'hFF);
      rd_chk(ADDR_SEC_MASK, MASK_USED);
      wr(ADDR_OT_MASK, 8'hFF);
      rd_chk(ADDR_OT_MASK, MASK_USED);
      wr(ADDR_OT_MASK, 8'h00);
      for (int b = 0; b < 7; b++) begin
         wr(ADDR_SEC_MASK, MASK_USED ^ (8'h01 << b));
         cv = 14'h0001 << b;
         pins(4'hF);
         wr(ADDR_SEC_MASK, 8'h01 << b);
         pins(4'h7);
         if (b < 3) begin
            vin_en = 8'h00;
            pins(4'hF);
            vin_en = 8'hFF;
         end
         cv = 14'h0000;
         pins(4'hF);
      end
      wr(ADDR_SEC_MASK, 8'h00);
      for (int b = 0; b < 7; b++) begin
         wr(ADDR_OT_MASK, MASK_USED ^ (8'h01 << b));
         cv = 14'h0080 << b;
         pins(4'hF);
         wr(ADDR_OT_MASK, 8'h01 << b);
         pins(4'hB);
         cv = 14'h0000;
         pins(b < 3 ? 4'hF : 4'hB);
         if (b >= 3) begin
            rd_chk(ADDR_STATUS, (8'h10 << (b - 3)) | 8'h02);
            wr(ADDR_LATCH_CLR, 8'h5A);
            pins(4'hF);
            rd_chk(ADDR_STATUS, 8'h00);
         end
      end
      wr(ADDR_OT_MASK, 8'h00);
      ae = 1'b1;
      cv = 14'h0001;
      wr(ADDR_SEC_MASK, 8'h01);
      pins(4'h6);
      rd_chk(ADDR_STATUS, 8'h01);
      cv = 14'h0000;
      pins(4'hF);
      ae = 1'b0;
      for (int f = 0; f < 8; f++) begin
         wr(ADDR_RST_CFG, 8'(f << TMO_LSB));
         rc = 1'b1;
         pins(4'hD);
         rd_chk(ADDR_STATUS, 8'h04);
         rc = 1'b0;
         n = 0;
         while (pin[1] !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
         end
         cmp(8'(n >= HU[f] * CLK_MHZ && n <= HU[f] * CLK_MHZ + 2), 8'h01);
         if (n == 1000) close_out();
      end
      close_out();
   end
endmodule
